// [bench/sssp_link_sva.sv]
/*
 * Checker on the link between the serial port slave and its master.
 * Assumes the master's default half period of three system cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module sssp_link_sva (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic sck,
    input wire logic dt_m,
    input wire logic dt_m_oe,
    input wire logic dt_s,
    input wire logic dt_s_oe
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ==================================================
    // Shift clock framing
    sck_high_a: assert property ($rose(sck) |-> sck [*3] ##1 !sck)
        else $error("shift clock high phase wrong");
    sck_low_a: assert property ($fell(sck) |-> !sck [*3])
        else $error("shift clock low phase too short");
    mst_start_a: assert property ($rose(dt_m_oe) |-> $rose(sck))
        else $error("master drive began off a leading edge");
    mst_stop_a: assert property ($fell(dt_m_oe) |-> !sck && !$past(sck))
        else $error("master drive ended inside a bit");

    // ==================================================
    // Data line ownership and timing
    mst_hold_a: assert property ($fell(sck) && dt_m_oe |-> $stable(dt_m))
        else $error("master data moved at trailing edge");
    slv_hold_a: assert property ($fell(sck) && dt_s_oe |-> $stable(dt_s))
        else $error("slave data moved at trailing edge");
    one_driver_a: assert property (!(dt_m_oe && dt_s_oe))
        else $error("both ends drive the data line");
    slv_oe_steady_a: assert property (sck |-> $stable(dt_s_oe))
        else $error("slave drive enable moved inside a frame");
endmodule : sssp_link_sva
`default_nettype wire

// [bench/sync_slave_serial_port_tb.sv]
/*
 * Bench joining the serial port slave and master over one link.
 * Assumes the package constants and the master's default half period.
 */
`timescale 1ns/100ps
`default_nettype none
module sync_slave_serial_port_tb;
    import sssp_pkg::*;
    logic sys_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [REG_AW-1:0] reg_addr = 3'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic irq;
    logic wake;
    logic start = 1'h0;
    logic transmit = 1'h0;
    logic nine = 1'h0;
    sssp_char_t tx_word = 9'h000;
    sssp_char_t rx_word;
    logic done;
    int n_errors = 0;
    int cmp_count = 0;

    sssp_link_if link ();
    sssp_device i_sssp_device (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .irq_o(irq),
        .wake_o(wake), .link(link.dev));
    sssp_master i_sssp_master (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .start_i(start), .transmit_i(transmit), .nine_i(nine), .tx_word_i(tx_word),
        .busy_o(), .done_o(done), .rx_word_o(rx_word), .link(link.mst));
    sssp_link_sva i_sssp_link_sva (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .sck(link.sck), .dt_m(link.dt_m), .dt_m_oe(link.dt_m_oe),
        .dt_s(link.dt_s), .dt_s_oe(link.dt_s_oe));

    always #4 sys_clk_i = ~sys_clk_i;

    // ==================================================
    // Shared tasks
    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge sys_clk_i);
        reg_wr = 1'h0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge sys_clk_i);
        reg_rd = 1'h0;
        d = reg_rdata;
    endtask : rd

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({1'h0, d}, {1'h0, exp});
    endtask : rdchk

    task automatic frame(input logic tx, input logic n9, input sssp_char_t w,
                         output sssp_char_t r);
        int i;
        @(negedge sys_clk_i);
        transmit = tx;
        nine = n9;
        tx_word = w;
        start = 1'h1;
        @(negedge sys_clk_i);
        start = 1'h0;
        for (i = 0; i < 300 && done !== 1'h1; i++)
            @(negedge sys_clk_i);
        chk({8'h00, done}, 9'h001);
        r = rx_word;
        repeat (8) @(negedge sys_clk_i);
    endtask : frame

    // ==================================================
    // Scenarios
    task automatic t_port_off();
        rdchk(REG_RX_STAT, 8'h00);
        wr(REG_RX_STAT, 8'h30);
        wr(REG_TX_STAT, 8'h30);
        rdchk(REG_RX_STAT, 8'h00);
        rdchk(REG_TX_STAT, 8'h12);
    endtask : t_port_off

    task automatic t_rx8();
        logic [7:0] d;
        sssp_char_t r;
        wr(REG_TX_STAT, 8'h10);
        wr(REG_RX_STAT, 8'hB0);
        wr(REG_IRQ_CTRL, 8'h60);
        frame(1'h1, 1'h0, 9'h0A5, r);
        chk({8'h00, wake}, 9'h001);
        chk({8'h00, irq}, 9'h000);
        rd(REG_IRQ_CTRL, d);
        chk({8'h00, d[IRQ_RX_FLAG]}, 9'h001);
        wr(REG_IRQ_CTRL, 8'hE0);
        repeat (2) @(negedge sys_clk_i);
        chk({8'h00, irq}, 9'h001);
        rdchk(REG_RX_BUF, 8'hA5);
        rd(REG_IRQ_CTRL, d);
        chk({8'h00, d[IRQ_RX_FLAG]}, 9'h000);
    endtask : t_rx8

    task automatic t_rx9_overrun();
        sssp_char_t r;
        wr(REG_RX_STAT, 8'hD0);
        frame(1'h1, 1'h1, 9'h1C3, r);
        frame(1'h1, 1'h1, 9'h055, r);
        frame(1'h1, 1'h1, 9'h1AA, r);
        frame(1'h1, 1'h1, 9'h0FF, r);
        rdchk(REG_RX_STAT, 8'hD3);
        rdchk(REG_RX_BUF, 8'hC3);
        rdchk(REG_RX_STAT, 8'hD2);
        rdchk(REG_RX_BUF, 8'h55);
        rdchk(REG_RX_BUF, 8'h00);
        wr(REG_RX_STAT, 8'hC0);
        rdchk(REG_RX_STAT, 8'hC0);
    endtask : t_rx9_overrun

    task automatic t_tx9();
        logic [7:0] d;
        sssp_char_t r;
        wr(REG_RX_STAT, 8'h80);
        wr(REG_TX_STAT, 8'h51);
        wr(REG_TX_HOLD, 8'h3C);
        repeat (4) @(negedge sys_clk_i);
        // Transmit off: idle frame length follows the receive width
        frame(1'h0, 1'h0, 9'h000, r);
        chk(r, 9'h0FF);
        wr(REG_TX_STAT, 8'h71);
        wr(REG_TX_HOLD, 8'h3C);
        repeat (4) @(negedge sys_clk_i);
        rd(REG_TX_STAT, d);
        chk({8'h00, d[TX_SHIFT_EMPTY]}, 9'h000);
        frame(1'h0, 1'h1, 9'h000, r);
        chk(r, 9'h13C);
    endtask : t_tx9

    initial
    begin
        repeat (20) @(negedge sys_clk_i);
        sys_rst_i = 1'h0;
        t_port_off();
        t_rx8();
        t_rx9_overrun();
        t_tx9();
        test_done();
    end

    initial
    begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : sync_slave_serial_port_tb
`default_nettype wire

// [hw/sssp_device.sv]
/*
 * Synchronous slave serial port: register file on the system clock,
 * shift logic on the link clock supplied by the external master.
 * Assumes configuration bits change only while the link clock is idle.
 */
`timescale 1ns/100ps
`default_nettype none
module sssp_device #(
    parameter int RX_DEPTH = sssp_pkg::RX_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [sssp_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    output logic wake_o,
    sssp_link_if.dev link
);
    import sssp_pkg::*;

    localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam logic [PW:0] DEPTH_FULL = (PW + 1)'(RX_DEPTH);

    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
    begin : g_depth_check
        $error("RX_DEPTH must be a power of two of at least 2");
    end

    // ==================================================
    // Register state
    logic port_enable, nine_rx, single_rx_en, cont_rx_en, addr_det;
    logic clock_source_master, nine_tx, transmit_enable, sync_mode;
    logic send_break, high_speed, transmit_ninth_bit;
    logic global_irq_enable, peripheral_irq_enable, rx_ie, tx_ie;
    logic [7:0] baud_ctrl, div_lo, div_hi;
    logic overrun;
    sssp_char_t hold_word, launch_word;
    logic hold_full, launch_busy, tx_drive, lnk_rst;
    sssp_char_t rx_fifo [RX_DEPTH];
    logic [PW-1:0] rd_ptr, wr_ptr;
    logic [PW:0] rx_count;
    logic [2:0] tx_done_sync, rx_done_sync;
    // Link domain
    logic [3:0] bit_cnt;
    sssp_char_t receive_shift_register, transmit_shift_register, rx_word_lnk;
    logic rx_done_tog, tx_done_tog, dt_out;

    logic slave_on, tx_mode, rx_on, tx_done_evt, rx_evt, push, pop, ovf;
    logic wr_rx_stat, wr_tx_stat, receive_complete_flag, transmit_ready_flag, next_wake;
    logic [3:0] frame_last;
    logic [7:0] rd_word;

    assign slave_on = port_enable & sync_mode & ~clock_source_master;
    assign tx_mode = slave_on & ~cont_rx_en & ~single_rx_en;
    assign rx_on = slave_on & cont_rx_en;
    assign wr_rx_stat = reg_wr_i && reg_addr_i == REG_RX_STAT;
    assign wr_tx_stat = reg_wr_i && reg_addr_i == REG_TX_STAT;
    assign tx_done_evt = tx_done_sync[2] ^ tx_done_sync[1];
    assign rx_evt = rx_done_sync[2] ^ rx_done_sync[1];
    assign pop = reg_rd_i && reg_addr_i == REG_RX_BUF && rx_count != '0;
    assign push = rx_evt & rx_on & ~overrun & (rx_count != DEPTH_FULL);
    assign ovf = rx_evt & rx_on & ~overrun & (rx_count == DEPTH_FULL);
    assign receive_complete_flag = rx_count != '0;
    assign transmit_ready_flag = ~hold_full;

    // ==================================================
    // Control registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            {port_enable, nine_rx, single_rx_en, cont_rx_en, addr_det} <= '0;
        end
        else if (wr_rx_stat)
        begin
            port_enable <= reg_wdata_i[RX_PORT_EN];
            nine_rx <= reg_wdata_i[RX_NINE];
            single_rx_en <= reg_wdata_i[RX_SINGLE];
            cont_rx_en <= reg_wdata_i[RX_CONT];
            addr_det <= reg_wdata_i[RX_ADDR];
        end
        else if (!port_enable)
        begin
            single_rx_en <= 1'h0;
            cont_rx_en <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            {clock_source_master, nine_tx, transmit_enable, sync_mode} <= '0;
            {send_break, high_speed, transmit_ninth_bit} <= '0;
        end
        else if (wr_tx_stat)
        begin
            clock_source_master <= reg_wdata_i[TX_CLK_MASTER];
            nine_tx <= reg_wdata_i[TX_NINE];
            transmit_enable <= reg_wdata_i[TX_EN];
            sync_mode <= reg_wdata_i[TX_SYNC];
            send_break <= reg_wdata_i[TX_BREAK];
            high_speed <= reg_wdata_i[TX_HIGH_SPEED];
            transmit_ninth_bit <= reg_wdata_i[TX_NINTH];
        end
        else if (!port_enable)
        begin
            transmit_enable <= 1'h0;
        end
    end

    // Divisor and baud bits are stored only; shifting never uses them
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            baud_ctrl <= RST_BYTE;
            div_lo <= RST_BYTE;
            div_hi <= RST_BYTE;
            {global_irq_enable, peripheral_irq_enable, rx_ie, tx_ie} <= '0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                REG_BAUD_CTRL: baud_ctrl <= reg_wdata_i & BAUD_WR_MASK;
                REG_DIV_LO: div_lo <= reg_wdata_i;
                REG_DIV_HI: div_hi <= reg_wdata_i;
                REG_IRQ_CTRL:
                begin
                    global_irq_enable <= reg_wdata_i[IRQ_GLOBAL];
                    peripheral_irq_enable <= reg_wdata_i[IRQ_PERIPH];
                    rx_ie <= reg_wdata_i[IRQ_RX_EN];
                    tx_ie <= reg_wdata_i[IRQ_TX_EN];
                end
                default: ;
            endcase
        end
    end

    // ==================================================
    // Transmit path: holding register to launch register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hold_word <= '0;
            launch_word <= '0;
            hold_full <= 1'h0;
            launch_busy <= 1'h0;
            tx_drive <= 1'h0;
        end
        else
        begin
            tx_drive <= tx_mode & transmit_enable;
            if (!port_enable)
            begin
                hold_full <= 1'h0;
                launch_busy <= 1'h0;
            end
            else
            begin
                if (tx_done_evt)
                    launch_busy <= 1'h0;
                if (hold_full && !launch_busy && transmit_enable && tx_mode)
                begin
                    launch_word <= nine_tx ? hold_word : {1'h0, hold_word[7:0]};
                    launch_busy <= 1'h1;
                    hold_full <= 1'h0;
                end
                if (reg_wr_i && reg_addr_i == REG_TX_HOLD)
                begin
                    hold_word <= {transmit_ninth_bit, reg_wdata_i};
                    hold_full <= 1'h1;
                end
            end
        end
    end

    // ==================================================
    // Receive FIFO and overrun
    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            rx_fifo[wr_ptr] <= rx_word_lnk;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            rx_count <= '0;
            overrun <= 1'h0;
        end
        else if (!port_enable)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            rx_count <= '0;
            overrun <= 1'h0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + PW'(1);
            if (pop)
                rd_ptr <= rd_ptr + PW'(1);
            case ({push, pop})
                2'h2: rx_count <= rx_count + (PW + 1)'(1);
                2'h1: rx_count <= rx_count - (PW + 1)'(1);
                default: rx_count <= rx_count;
            endcase
            if (ovf)
                overrun <= 1'h1;
            else if (!cont_rx_en)
                overrun <= 1'h0;
        end
    end

    // ==================================================
    // Crossings to and from the link domain
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tx_done_sync <= '0;
            rx_done_sync <= '0;
            lnk_rst <= 1'h1;
        end
        else
        begin
            tx_done_sync <= {tx_done_sync[1:0], tx_done_tog};
            rx_done_sync <= {rx_done_sync[1:0], rx_done_tog};
            lnk_rst <= ~port_enable;
        end
    end

    // ==================================================
    // Register read and interrupt outputs
    always_comb
    begin
        rd_word = RD_NONE;
        case (reg_addr_i)
            REG_BAUD_CTRL: rd_word = baud_ctrl;
            REG_RX_STAT:
            begin
                rd_word[RX_PORT_EN] = port_enable;
                rd_word[RX_NINE] = nine_rx;
                rd_word[RX_SINGLE] = single_rx_en;
                rd_word[RX_CONT] = cont_rx_en;
                rd_word[RX_ADDR] = addr_det;
                rd_word[RX_OVERRUN] = overrun;
                rd_word[RX_NINTH] = receive_complete_flag & rx_fifo[rd_ptr][8];
            end
            REG_DIV_LO: rd_word = div_lo;
            REG_DIV_HI: rd_word = div_hi;
            REG_TX_STAT:
            begin
                rd_word[TX_CLK_MASTER] = clock_source_master;
                rd_word[TX_NINE] = nine_tx;
                rd_word[TX_EN] = transmit_enable;
                rd_word[TX_SYNC] = sync_mode;
                rd_word[TX_BREAK] = send_break;
                rd_word[TX_HIGH_SPEED] = high_speed;
                rd_word[TX_SHIFT_EMPTY] = ~launch_busy;
                rd_word[TX_NINTH] = transmit_ninth_bit;
            end
            REG_RX_BUF: rd_word = receive_complete_flag ? rx_fifo[rd_ptr][7:0] : RD_NONE;
            REG_IRQ_CTRL:
            begin
                rd_word[IRQ_GLOBAL] = global_irq_enable;
                rd_word[IRQ_PERIPH] = peripheral_irq_enable;
                rd_word[IRQ_RX_EN] = rx_ie;
                rd_word[IRQ_TX_EN] = tx_ie;
                rd_word[IRQ_RX_FLAG] = receive_complete_flag;
                rd_word[IRQ_TX_FLAG] = transmit_ready_flag;
            end
            default: rd_word = RD_NONE;
        endcase
    end

    assign next_wake = peripheral_irq_enable & ((receive_complete_flag & rx_ie) | (transmit_ready_flag & tx_ie));

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= RST_BYTE;
            wake_o <= 1'h0;
            irq_o <= 1'h0;
        end
        else
        begin
            if (reg_rd_i)
                reg_rdata_o <= rd_word;
            wake_o <= next_wake;
            irq_o <= next_wake & global_irq_enable;
        end
    end

    // ==================================================
    // Link domain: sample on trailing, change on leading edge
    assign frame_last = (tx_drive ? nine_tx : nine_rx) ? CHAR_LAST_NINE : CHAR_LAST_EIGHT;

    always_ff @(negedge link.sck or posedge lnk_rst)
    begin
        if (lnk_rst)
        begin
            bit_cnt <= '0;
            receive_shift_register <= '0;
            rx_word_lnk <= '0;
            rx_done_tog <= 1'h0;
            tx_done_tog <= 1'h0;
        end
        else
        begin
            receive_shift_register <= {link.dt, receive_shift_register[8:1]};
            if (bit_cnt == frame_last)
            begin
                bit_cnt <= '0;
                if (!tx_drive)
                begin
                    rx_word_lnk <= nine_rx ? {link.dt, receive_shift_register[8:1]}
                                           : {1'h0, link.dt, receive_shift_register[8:2]};
                    rx_done_tog <= ~rx_done_tog;
                end
                else
                    tx_done_tog <= ~tx_done_tog;
            end
            else
                bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge link.sck or posedge lnk_rst)
    begin
        if (lnk_rst)
        begin
            transmit_shift_register <= '0;
            dt_out <= 1'h1;
        end
        else if (bit_cnt == '0)
        begin
            dt_out <= launch_word[0];
            transmit_shift_register <= {1'h0, launch_word[8:1]};
        end
        else
        begin
            dt_out <= transmit_shift_register[0];
            transmit_shift_register <= {1'h0, transmit_shift_register[8:1]};
        end
    end

    assign link.dt_s = dt_out;
    assign link.dt_s_oe = tx_drive;
endmodule : sssp_device
`default_nettype wire

// [hw/sssp_master.sv]
/*
 * External synchronous master: divides the system clock into the shift
 * clock, sends or receives one character per request.
 * Assumes the slave end shares the link interface.
 */
`timescale 1ns/100ps
`default_nettype none
module sssp_master #(
    parameter int HALF_CYCLES = sssp_pkg::LINK_HALF_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic transmit_i,
    input wire logic nine_i,
    input wire sssp_pkg::sssp_char_t tx_word_i,
    output logic busy_o,
    output logic done_o,
    output sssp_pkg::sssp_char_t rx_word_o,
    sssp_link_if.mst link
);
    import sssp_pkg::*;

    if (HALF_CYCLES < 3 || HALF_CYCLES > 255)
    begin : g_half_check
        $error("HALF_CYCLES must lie in 3..255");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    typedef enum logic [1:0] {M_IDLE, M_HIGH, M_LOW} sssp_mstate_t;

    sssp_mstate_t state;
    logic [7:0] timer;
    logic [3:0] bit_idx, last;
    sssp_char_t shreg, rxsh;
    logic sck, dt_m, dt_oe;
    logic [1:0] dt_sync;

    // ==================================================
    // Data line synchroniser
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            dt_sync <= 2'h3;
        else
            dt_sync <= {dt_sync[0], link.dt};
    end

    // ==================================================
    // Frame sequencer: one clock per bit, exact count
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state <= M_IDLE;
            {timer, bit_idx, last} <= '0;
            {shreg, rxsh, rx_word_o} <= '0;
            {sck, dt_oe, busy_o, done_o} <= '0;
            dt_m <= 1'h1;
        end
        else
        begin
            done_o <= 1'h0;
            timer <= timer + 8'h01;
            case (state)
                M_IDLE:
                    if (start_i)
                    begin
                        last <= nine_i ? CHAR_LAST_NINE : CHAR_LAST_EIGHT;
                        bit_idx <= '0;
                        busy_o <= 1'h1;
                        dt_oe <= transmit_i;
                        dt_m <= tx_word_i[0];
                        shreg <= {1'h0, tx_word_i[8:1]};
                        sck <= 1'h1;
                        timer <= '0;
                        state <= M_HIGH;
                    end
                M_HIGH:
                    if (timer == HALF_LAST)
                    begin
                        sck <= 1'h0;
                        rxsh <= {dt_sync[1], rxsh[8:1]};
                        timer <= '0;
                        state <= M_LOW;
                    end
                M_LOW:
                    if (timer == HALF_LAST)
                    begin
                        timer <= '0;
                        if (bit_idx == last)
                        begin
                            rx_word_o <= (last == CHAR_LAST_NINE) ? rxsh : {1'h0, rxsh[8:1]};
                            done_o <= 1'h1;
                            busy_o <= 1'h0;
                            dt_oe <= 1'h0;
                            state <= M_IDLE;
                        end
                        else
                        begin
                            bit_idx <= bit_idx + 4'h1;
                            dt_m <= shreg[0];
                            shreg <= {1'h0, shreg[8:1]};
                            sck <= 1'h1;
                            state <= M_HIGH;
                        end
                    end
                default: state <= M_IDLE;
            endcase
        end
    end

    assign link.sck = sck;
    assign link.dt_m = dt_m;
    assign link.dt_m_oe = dt_oe;
endmodule : sssp_master
`default_nettype wire

// [shared/sssp_link_if.sv]
/*
 * Link between the serial port slave and the external master: shift
 * clock from the master and one shared data line.
 * Assumes at most one end enables its data driver at a time.
 */
`timescale 1ns/100ps
`default_nettype none
interface sssp_link_if;
    logic sck;
    logic dt_m;
    logic dt_m_oe;
    logic dt_s;
    logic dt_s_oe;
    logic dt;

    // Line pulled high when nobody drives it
    assign dt = dt_s_oe ? dt_s : (dt_m_oe ? dt_m : 1'h1);

    modport dev (input sck, input dt, output dt_s, output dt_s_oe);
    modport mst (output sck, output dt_m, output dt_m_oe, input dt);
endinterface : sssp_link_if
`default_nettype wire

// [shared/sssp_pkg.sv]
/*
 * Constants shared by both ends of the synchronous slave serial port:
 * register indices, field positions, reset values and link timing.
 * Assumes a 125 MHz system clock and an 8- or 9-bit character.
 */
package sssp_pkg;
    // ==================================================
    // Register indices
    localparam int REG_AW = 3;
    localparam logic [REG_AW-1:0] REG_BAUD_CTRL = 3'h0;
    localparam logic [REG_AW-1:0] REG_RX_STAT = 3'h1;
    localparam logic [REG_AW-1:0] REG_DIV_LO = 3'h2;
    localparam logic [REG_AW-1:0] REG_DIV_HI = 3'h3;
    localparam logic [REG_AW-1:0] REG_TX_HOLD = 3'h4;
    localparam logic [REG_AW-1:0] REG_TX_STAT = 3'h5;
    localparam logic [REG_AW-1:0] REG_RX_BUF = 3'h6;
    localparam logic [REG_AW-1:0] REG_IRQ_CTRL = 3'h7;

    // ==================================================
    // Field positions
    localparam int RX_PORT_EN = 7;
    localparam int RX_NINE = 6;
    localparam int RX_SINGLE = 5;
    localparam int RX_CONT = 4;
    localparam int RX_ADDR = 3;
    localparam int RX_OVERRUN = 1;
    localparam int RX_NINTH = 0;
    localparam int TX_CLK_MASTER = 7;
    localparam int TX_NINE = 6;
    localparam int TX_EN = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_BREAK = 3;
    localparam int TX_HIGH_SPEED = 2;
    localparam int TX_SHIFT_EMPTY = 1;
    localparam int TX_NINTH = 0;
    localparam int IRQ_GLOBAL = 7;
    localparam int IRQ_PERIPH = 6;
    localparam int IRQ_RX_EN = 5;
    localparam int IRQ_TX_EN = 4;
    localparam int IRQ_RX_FLAG = 1;
    localparam int IRQ_TX_FLAG = 0;

    // ==================================================
    // Reset values and masks
    localparam logic [7:0] BAUD_WR_MASK = 8'h1B;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RD_NONE = 8'h00;

    // ==================================================
    // Character and link timing
    typedef logic [8:0] sssp_char_t;
    localparam logic [3:0] CHAR_LAST_NINE = 4'h8;
    localparam logic [3:0] CHAR_LAST_EIGHT = 4'h7;
    localparam int RX_FIFO_DEPTH = 2;
    localparam int SYS_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 48;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
endpackage : sssp_pkg
